// >>> hw/qups_pin_status.sv
// Functional notes
// RULE1: Select high in mode 16 forces interrupts driven
// RULE2: Otherwise interrupt outputs enabled by control bit 3
// RULE3: Host keeps select low in mode 68
// RULE4: Per-channel transmit ready reflects transmit FIFO
// RULE5: Per-channel receive ready reflects receive FIFO
// RULE6: Combined transmit ready ANDs four channels
// RULE7: Combined receive ready ANDs four channels
// RULE8: Status select low puts status on bus
// RULE9: Low nibble inverted tx, high nibble rx
// RULE10: Status read ignores address lines
// RULE11: Bit 6 clear: standard, transmit idles high
// RULE12: Bit 6 set: infrared, transmit idles low
// RULE13: Dedicated infrared output always infrared, idles low
// RULE14: Receive input idles high in standard mode
// RULE15: Software asserts RTS before auto RTS
// RULE16: Auto CTS uses clear-to-send when enabled
// RULE17: DTR and RTS serve as general outputs
// RULE18: Bus mode select high means mode 16
// RULE19: Control bit 3 resets to zero
`timescale 1ns/100ps
`default_nettype none

module qups_pin_status
  import qups_pkg::*;
(
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rst_in,
  // Mode straps
  input  wire logic                          bus_mode_select_in,
  input  wire logic                          interrupt_select_input_in,
  // Register contents per channel
  input  wire qups_pkg::qups_ctrl_t          ctrl_in [qups_pkg::NUM_CH],
  input  wire qups_pkg::qups_core_t          core_in [qups_pkg::NUM_CH],
  // FIFO levels per channel, active low readiness
  input  wire logic [qups_pkg::NUM_CH-1:0]   tx_ready_core_n_in,
  input  wire logic [qups_pkg::NUM_CH-1:0]   rx_ready_core_n_in,
  // Serial side inputs
  input  wire logic [qups_pkg::NUM_CH-1:0]   rx_pin_in,
  input  wire logic [qups_pkg::NUM_CH-1:0]   cts_n_in,
  // Host status read port
  input  wire logic                          fifo_status_select_n_in,
  input  wire logic                          status_ready_in,
  output logic                               status_valid_out,
  output logic [7:0]                         data_bus_out,
  output logic                               data_bus_oe_out,
  // Interrupt pins
  output logic [qups_pkg::NUM_CH-1:0]        int_out,
  output logic [qups_pkg::NUM_CH-1:0]        int_oe_out,
  // Ready pins
  output logic [qups_pkg::NUM_CH-1:0]        tx_ready_n_out,
  output logic [qups_pkg::NUM_CH-1:0]        rx_ready_n_out,
  output logic                               tx_ready_all_n_out,
  output logic                               rx_ready_all_n_out,
  // Serial pins
  output logic [qups_pkg::NUM_CH-1:0]        tx_out,
  output logic [qups_pkg::NUM_CH-1:0]        infrared_tx_out,
  output logic [qups_pkg::NUM_CH-1:0]        rts_n_out,
  output logic [qups_pkg::NUM_CH-1:0]        dtr_n_out,
  // Decoded serial side towards the core
  output logic [qups_pkg::NUM_CH-1:0]        rx_serial_out,
  output logic [qups_pkg::NUM_CH-1:0]        rx_ir_out,
  output logic [qups_pkg::NUM_CH-1:0]        cts_halt_out,
  output logic [qups_pkg::NUM_CH-1:0]        cts_irq_en_out,
  output logic [qups_pkg::NUM_CH-1:0]        rts_auto_en_out
);
  import qups_pkg::*;

  // ==========================================================
  // Mode
  logic mode16;
  assign mode16 = bus_mode_select_in; // RULE18

  // ==========================================================
  // Per-channel pin logic
  logic [7:0] next_status;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic ir_mode;
      logic int_en;
      assign ir_mode = ctrl_in[ch].modem_control_reg[MCR_IR_BIT];
      // Mode 68 leaves B-D unused at zero; A stays open-drain style
      assign int_en  = interrupt_select_input_in // RULE1
                     | ctrl_in[ch].modem_control_reg[MCR_INTE_BIT]; // RULE2

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          int_out[ch]    <= 1'b0;
          int_oe_out[ch] <= 1'b0; // RULE19
        end else if (mode16) begin
          int_out[ch]    <= core_in[ch].irq;
          int_oe_out[ch] <= int_en; // RULE1 RULE2
        end else if (ch == 0) begin
          // Active-low open-drain device interrupt, drive low only
          int_out[ch]    <= 1'b0;
          int_oe_out[ch] <= core_in[ch].irq;
        end else begin
          int_out[ch]    <= 1'b0;
          int_oe_out[ch] <= 1'b1;
        end
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          tx_ready_n_out[ch]  <= 1'b1;
          rx_ready_n_out[ch]  <= 1'b1;
          tx_out[ch]          <= 1'b1; // RULE11
          infrared_tx_out[ch] <= 1'b0; // RULE13
          rts_n_out[ch]       <= 1'b1;
          dtr_n_out[ch]       <= 1'b1;
        end else begin
          tx_ready_n_out[ch]  <= tx_ready_core_n_in[ch]; // RULE4
          rx_ready_n_out[ch]  <= rx_ready_core_n_in[ch]; // RULE5
          tx_out[ch]          <= ir_mode ? core_in[ch].tx_ir // RULE12
                                         : core_in[ch].tx_serial; // RULE11
          infrared_tx_out[ch] <= core_in[ch].tx_ir; // RULE13
          rts_n_out[ch]       <= ~core_in[ch].rts_level; // RULE17
          dtr_n_out[ch]       <= // RULE17
            ~ctrl_in[ch].modem_control_reg[MCR_DTR_BIT];
        end
      end

      // Receive path split by mode; standard input assumed idle high
      assign rx_serial_out[ch] = ir_mode ? 1'b1 : rx_pin_in[ch]; // RULE14
      assign rx_ir_out[ch]     = ir_mode ? rx_pin_in[ch] : 1'b0; // RULE12

      assign cts_halt_out[ch]   = // RULE16
        ctrl_in[ch].enhanced_feature_reg[EFR_ACTS_BIT] & cts_n_in[ch];
      assign cts_irq_en_out[ch] = // RULE16
        ctrl_in[ch].interrupt_enable_reg[IER_CTS_BIT];
      // Software must already hold RTS asserted when enabling this
      assign rts_auto_en_out[ch] = // RULE15
        ctrl_in[ch].enhanced_feature_reg[EFR_ARTS_BIT]
        & ctrl_in[ch].interrupt_enable_reg[IER_RTS_BIT];

      assign next_status[FSW_TX_LSB+ch] = ~tx_ready_n_out[ch]; // RULE9
      assign next_status[FSW_RX_LSB+ch] = rx_ready_n_out[ch]; // RULE9
    end
  endgenerate

  assign tx_ready_all_n_out = &tx_ready_n_out; // RULE6
  assign rx_ready_all_n_out = &rx_ready_n_out; // RULE7

  // ==========================================================
  // Two-entry status buffer
  // Stops sampling once both entries fill while the reader stalls; the
  // older snapshot is presented and the newer one waits behind it.
  qups_stat_t buf_q [2];
  logic [1:0] count;
  logic       rd_ptr;
  logic       wr_ptr;
  logic       push;
  logic       pop;
  logic       buf_ready;

  assign buf_ready        = (count != 2'd2);
  assign push             = buf_ready; // Snapshot every free cycle
  assign status_valid_out = (count != 2'd0);
  assign pop              = status_valid_out & status_ready_in;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wr_ptr   <= 1'b0;
    end else if (push) begin
      buf_q[wr_ptr].word <= next_status;
      wr_ptr             <= ~wr_ptr;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================================
  // Data bus drive, no address decode needed
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_bus_out    <= 8'h00;
      data_bus_oe_out <= 1'b0;
    end else begin
      data_bus_oe_out <= ~fifo_status_select_n_in; // RULE8 RULE10
      data_bus_out    <= buf_q[rd_ptr].word; // RULE8
    end
  end

endmodule // qups_pin_status

`default_nettype wire

// >>> hw/qups_pkg.sv
package qups_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_CH = 4;

  // ==========================================================
  // Modem control bit positions
  localparam int MCR_RTS_BIT  = 1;
  localparam int MCR_INTE_BIT = 3;
  localparam int MCR_IR_BIT   = 6;
  localparam int MCR_DTR_BIT  = 0;

  // ==========================================================
  // Feature and interrupt enable bit positions
  localparam int EFR_ARTS_BIT = 6;
  localparam int EFR_ACTS_BIT = 7;
  localparam int IER_RTS_BIT  = 6;
  localparam int IER_CTS_BIT  = 7;

  // ==========================================================
  // Status word layout
  localparam int FSW_TX_LSB = 0;
  localparam int FSW_RX_LSB = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] EFR_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;

  // ==========================================================
  // Per-channel control bundle from the UART core registers
  typedef struct packed {
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
  } qups_ctrl_t;

  // Per-channel serial engine outputs
  typedef struct packed {
    logic tx_serial;
    logic tx_ir;
    logic rts_level;
    logic irq;
  } qups_core_t;

  // Buffered status word
  typedef struct packed {
    logic [7:0] word;
  } qups_stat_t;

  typedef enum logic [1:0] {
    QUPS_EMPTY = 2'b01,
    QUPS_FULL  = 2'b10
  } qups_buf_state_t;

endpackage

// >>> verification/qups_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Serial transceivers and status reader
module qups_far_end (
  // Clock and stall control
  input  wire logic       mclk_in,
  input  wire logic       stall_in,
  // Lines towards the block
  output logic      [3:0] rx_pin_out,
  output logic            ready_out
);
  // No frames sent, so every line sits idle
  assign rx_pin_out = 4'hF;
  always_ff @(posedge mclk_in) ready_out <= !stall_in;
endmodule // qups_far_end
`default_nettype wire

// >>> verification/qups_pin_status_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Pin behaviour checker
module qups_pin_status_asserts
  import qups_pkg::*;
(
  // Clock and reset
  input wire logic                mclk_in,
  input wire logic                rst_in,
  // Observed inputs
  input wire logic                bus_mode_select_in,
  input wire logic                interrupt_select_input_in,
  input wire qups_pkg::qups_ctrl_t ctrl_in [qups_pkg::NUM_CH],
  input wire qups_pkg::qups_core_t core_in [qups_pkg::NUM_CH],
  input wire logic [3:0]          tx_ready_core_n_in,
  input wire logic [3:0]          rx_ready_core_n_in,
  input wire logic                fifo_status_select_n_in,
  // Observed outputs
  input wire logic                data_bus_oe_out,
  input wire logic [3:0]          int_oe_out,
  input wire logic [3:0]          tx_ready_n_out,
  input wire logic [3:0]          rx_ready_n_out,
  input wire logic                tx_ready_all_n_out,
  input wire logic                rx_ready_all_n_out,
  input wire logic [3:0]          tx_out,
  input wire logic [3:0]          infrared_tx_out
);
  logic [3:0] inte, txe, irv;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      inte[i] = ctrl_in[i].modem_control_reg[MCR_INTE_BIT];
      irv[i]  = core_in[i].tx_ir;
      txe[i]  = ctrl_in[i].modem_control_reg[MCR_IR_BIT] ?
                core_in[i].tx_ir : core_in[i].tx_serial;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_sel_fall;
    $fell(fifo_status_select_n_in);
  endsequence
  a_int_forced_on: assert property (
    bus_mode_select_in && interrupt_select_input_in |=> int_oe_out == 4'hF)
    else $error("interrupt enable not forced");
  a_int_gate_bit: assert property (
    bus_mode_select_in && !interrupt_select_input_in
    |=> int_oe_out == $past(inte)) else $error("interrupt gate wrong");
  a_tx_ready_copy: assert property (1 |=>
    tx_ready_n_out == $past(tx_ready_core_n_in)) else $error("tx ready");
  a_rx_ready_copy: assert property (1 |=>
    rx_ready_n_out == $past(rx_ready_core_n_in)) else $error("rx ready");
  a_tx_all_and: assert property (
    tx_ready_all_n_out == &tx_ready_n_out) else $error("tx combined");
  a_rx_all_and: assert property (
    rx_ready_all_n_out == &rx_ready_n_out) else $error("rx combined");
  a_status_drive_on: assert property (
    s_sel_fall |=> data_bus_oe_out[*2]) else $error("status not driven");
  a_status_follow: assert property (1 |=>
    data_bus_oe_out == !$past(fifo_status_select_n_in))
    else $error("status enable wrong");
  a_tx_mode_sel: assert property (1 |=>
    tx_out == $past(txe)) else $error("transmit pin wrong");
  a_ir_dedicated: assert property (1 |=>
    infrared_tx_out == $past(irv)) else $error("infrared pin wrong");
endmodule // qups_pin_status_asserts
bind qups_pin_status qups_pin_status_asserts u_qups_pin_status_asserts (
  .mclk_in, .rst_in, .bus_mode_select_in, .interrupt_select_input_in,
  .ctrl_in, .core_in, .tx_ready_core_n_in, .rx_ready_core_n_in,
  .fifo_status_select_n_in, .data_bus_oe_out, .int_oe_out, .tx_ready_n_out,
  .rx_ready_n_out, .tx_ready_all_n_out, .rx_ready_all_n_out, .tx_out,
  .infrared_tx_out);
`default_nettype wire

// >>> verification/qups_pin_status_test.sv
`timescale 1ns/100ps
`default_nettype none
module qups_pin_status_test;
  import qups_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1, mode = 1'b1, isel = 1'b0;
  logic fsel_n = 1'b1, stall = 1'b0, rdy, sv, oe, ta, ra;
  logic [3:0] txc_n = 4'hF, rxc_n = 4'hF, cts_n = 4'hF, v;
  logic [3:0] rxp, io, tn, rn, tx, ir, dtr;
  logic [7:0] db;
  logic [3:0] iv, rs, rsr, rir, chl, cie, rae;
  qups_ctrl_t ctrl [NUM_CH];
  qups_core_t core [NUM_CH];
  int mismatches = 0, checked = 0, cycles = 0;
  initial forever #25 mclk_in = ~mclk_in;
  qups_far_end u_qups_far_end (.mclk_in(mclk_in), .stall_in(stall),
    .rx_pin_out(rxp), .ready_out(rdy));
  qups_pin_status u_qups_pin_status (.mclk_in(mclk_in), .rst_in(rst_in),
    .bus_mode_select_in(mode), .interrupt_select_input_in(isel),
    .ctrl_in(ctrl), .core_in(core), .tx_ready_core_n_in(txc_n),
    .rx_ready_core_n_in(rxc_n), .rx_pin_in(rxp), .cts_n_in(cts_n),
    .fifo_status_select_n_in(fsel_n), .status_ready_in(rdy),
    .status_valid_out(sv), .data_bus_out(db), .data_bus_oe_out(oe),
    .int_out(iv), .int_oe_out(io), .tx_ready_n_out(tn), .rx_ready_n_out(rn),
    .tx_ready_all_n_out(ta), .rx_ready_all_n_out(ra), .tx_out(tx),
    .infrared_tx_out(ir), .rts_n_out(rs), .dtr_n_out(dtr),
    .rx_serial_out(rsr), .rx_ir_out(rir), .cts_halt_out(chl),
    .cts_irq_en_out(cie), .rts_auto_en_out(rae));
  // ==========================================
  // Shared helpers
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end
  // ==========================================
  // Scenarios
  task automatic t_ints();
    @(posedge mclk_in);
    isel <= 1'b1;
    wt(1);
    chk("int_oe", {4'h0, io}, 8'h0F);
    @(posedge mclk_in);
    isel <= 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      ctrl[i].modem_control_reg[MCR_INTE_BIT] <= i[0];
    wt(1);
    chk("int_oe", {4'h0, io}, 8'h0A);
    @(posedge mclk_in);
    mode <= 1'b0;
    wt(1);
    // Unused channels are driven at zero, not floated
    chk("int_oe_68", {5'h0, io[3:1]}, 8'h07);
    chk("int_68", {4'h0, iv}, 8'h00);
    @(posedge mclk_in);
    mode <= 1'b1;
  endtask
  task automatic t_ready();
    for (int i = 0; i <= NUM_CH; i++) begin
      v = 4'(5'h1 << i);
      @(posedge mclk_in);
      txc_n <= ~v;
      rxc_n <= v;
      wt(1);
      chk("tx_rdy", {4'h0, tn}, {4'h0, ~v});
      chk("rx_rdy", {4'h0, rn}, {4'h0, v});
      chk("tx_all", {7'h0, ta}, {7'h0, &(~v)});
      chk("rx_all", {7'h0, ra}, {7'h0, &v});
    end
  endtask
  task automatic t_status();
    @(posedge mclk_in);
    txc_n <= 4'h5;
    rxc_n <= 4'h3;
    wt(6);
    @(posedge mclk_in);
    stall <= 1'b1;
    wt(4);
    chk("valid", {7'h0, sv}, 8'h01);
    @(posedge mclk_in);
    txc_n <= 4'hC;
    fsel_n <= 1'b0;
    wt(1);
    chk("bus_oe", {7'h0, oe}, 8'h01);
    chk("status", db, 8'h3A);
    @(posedge mclk_in);
    stall <= 1'b0;
    wt(6);
    chk("status", db, 8'h33);
    @(posedge mclk_in);
    fsel_n <= 1'b1;
    wt(1);
    chk("bus_oe", {7'h0, oe}, 8'h00);
  endtask
  task automatic t_serial();
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk_in);
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl[i].modem_control_reg[MCR_IR_BIT] <= m[0];
        ctrl[i].modem_control_reg[MCR_DTR_BIT] <= m[0];
        core[i].tx_ir <= !m[0];
      end
      wt(1);
      chk("tx", {4'h0, tx}, m ? 8'h00 : 8'h0F);
      chk("infrared_tx_out", {4'h0, ir}, m ? 8'h00 : 8'h0F);
      chk("dtr", {4'h0, dtr}, m ? 8'h00 : 8'h0F);
      chk("rx_std", {4'h0, rsr}, 8'h0F);
      chk("rx_ir", {4'h0, rir}, m ? 8'h0F : 8'h00);
    end
  endtask
  task automatic t_flow();
    @(posedge mclk_in);
    // Request-to-send asserted before any automatic flow is enabled
    for (int i = 0; i < NUM_CH; i++)
      core[i].rts_level <= 1'b1;
    wt(1);
    chk("rts_n", {4'h0, rs}, 8'h00);
    @(posedge mclk_in);
    for (int i = 0; i < NUM_CH; i++) begin
      ctrl[i].enhanced_feature_reg[EFR_ARTS_BIT] <= 1'b1;
      ctrl[i].interrupt_enable_reg[IER_RTS_BIT]  <= 1'b1;
      ctrl[i].enhanced_feature_reg[EFR_ACTS_BIT] <= 1'b1;
      ctrl[i].interrupt_enable_reg[IER_CTS_BIT]  <= 1'b1;
    end
    wt(1);
    chk("auto_rts", {4'h0, rae}, 8'h0F);
    chk("cts_ie", {4'h0, cie}, 8'h0F);
    chk("cts_halt", {4'h0, chl}, 8'h0F);
    @(posedge mclk_in);
    cts_n <= 4'h0;
    wt(1);
    chk("cts_halt", {4'h0, chl}, 8'h00);
  endtask
  initial begin
    for (int i = 0; i < NUM_CH; i++) begin
      ctrl[i] = '0;
      core[i] = '{tx_serial: 1'b1, default: 1'b0};
    end
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    wt(1);
    chk("int_oe", {4'h0, io}, 8'h00);
    chk("tx", {4'h0, tx}, 8'h0F);
    t_ints();
    t_ready();
    t_status();
    t_serial();
    t_flow();
    results();
  end
endmodule // qups_pin_status_test
`default_nettype wire
